// ---- common/bbx_defs.vh ----
// constants for the byte/bit instruction execute core
// Summary of operation
// - read of a port register for a byte op takes the pin levels, not the latch
// - any write of the timer-zero count clears its prescaler when assigned to it
// - a taken branch or true skip test costs a second, no-operation cycle
// - second word of a two-word op runs as no-operation unless first word uses it
// - bit set/clear force bit 0..7 of the file register, one cycle, flags unchanged
// - access bit zero picks the fixed access bank, one picks the bank select bank
// - branch if negative adds 2+2n to pc when N is set, else one cycle
// - relative branch adds 2+2n with 11-bit signed n, always two cycles
// - decrement file, write to destination, skip next when result is zero
// - increment file, write to destination, skip next when result is zero
// - inclusive or of working register and file, one cycle, updates Z and N only
// - unsigned 8x8 multiply of working register and file, one cycle, no flags
// - file-to-file move, two words 1100/1111 with 12-bit addresses, no flags
// - rotate left through carry, updates C, Z and N
// - compare file with working register, skip on equal, greater or less
// - bit test skips next when selected bit is clear or set, flags unchanged
// - subtract file from working register with borrow, updates all five flags
// - destination bit zero writes working register, one writes the file register
// - multiply puts 16-bit product in the product pair, working register kept
`ifndef BBX_DEFS_VH
`define BBX_DEFS_VH

// phases of one instruction cycle
`define BBX_PH_DECODE   2'h0
`define BBX_PH_READ     2'h1
`define BBX_PH_PROCESS  2'h2
`define BBX_PH_WRITE    2'h3

// status register bit positions and reset
`define BBX_ST_C        0
`define BBX_ST_HC       1
`define BBX_ST_Z        2
`define BBX_ST_VF       3
`define BBX_ST_N        4
`define BBX_ST_RESET    5'h00
`define BBX_FM_ZN       5'h14
`define BBX_FM_CZN      5'h15
`define BBX_FM_Z        5'h04
`define BBX_FM_ALL      5'h1f

// special addresses in the data space
`define BBX_ADDR_PORT   12'hf80
`define BBX_ADDR_TZC    12'hfd0
`define BBX_ADDR_BANK   12'hfe0
`define BBX_ACC_HI_BANK 4'hf

// reset values and fixed words
`define BBX_PC_RESET    21'h000000
`define BBX_NOP_WORD    16'h0000
`define BBX_PC_STEP     21'h000002

// major opcode nibbles
`define BBX_OP_MUL      4'h0
`define BBX_OP_IOR      4'h1
`define BBX_OP_DECSZ    4'h2
`define BBX_OP_INC_RLC  4'h3
`define BBX_OP_SNZ      4'h4
`define BBX_OP_MOV_SUB  4'h5
`define BBX_OP_CMP      4'h6
`define BBX_OP_BSET     4'h8
`define BBX_OP_BCLR     4'h9
`define BBX_OP_BTSS     4'ha
`define BBX_OP_BTSC     4'hb
`define BBX_OP_MFF1     4'hc
`define BBX_OP_REL      4'hd
`define BBX_OP_BR       4'he
`define BBX_OP_MFF2     4'hf
`define BBX_SUB_NEG     4'h6

// alu selects
`define BBX_ALU_PASSF   4'h0
`define BBX_ALU_OR      4'h1
`define BBX_ALU_DEC     4'h2
`define BBX_ALU_INC     4'h3
`define BBX_ALU_RLC     4'h4
`define BBX_ALU_SUBB    4'h5
`define BBX_ALU_BSET    4'h6
`define BBX_ALU_BCLR    4'h7
`define BBX_ALU_PASSW   4'h8
`define BBX_ALU_CLR     4'h9
`define BBX_ALU_SET     4'ha

`endif

// ---- design/bbx_sync.v ----
// two-flop synchroniser, one per bit
`timescale 1ns/100ps
`default_nettype none
module bbx_sync #(
  parameter W = 8
) (
  // clock and reset
  input  wire         clk,
  input  wire         nrst,
  // asynchronous in, synchronised out
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_r;
      reg stab_r;
      always @(posedge clk) begin
        if (!nrst) begin
          meta_r <= 1'b0;
          stab_r <= 1'b0;
        end else begin
          meta_r <= async_in[i];
          stab_r <= meta_r;
        end
      end
      assign sync_out[i] = stab_r;
    end
  endgenerate
endmodule
`default_nettype wire

// ---- design/bbx_alu.v ----
// data path for byte and bit operations
`timescale 1ns/100ps
`default_nettype none
`include "bbx_defs.vh"
module bbx_alu (
  // select and operands
  input  wire [3:0]  sel,
  input  wire [7:0]  fval,
  input  wire [7:0]  wval,
  input  wire        cin,
  input  wire [2:0]  bsel,
  // results
  output reg  [7:0]  res,
  output reg         c_out,
  output reg         hc_out,
  output reg         vf_out,
  output wire        z_out,
  output wire        n_out,
  output wire [15:0] prod
);
  reg [8:0] sum;
  reg [4:0] lsum;

  assign prod = {8'h00, wval} * {8'h00, fval};

  always @* begin
    sum    = 9'h000;
    lsum   = 5'h00;
    res    = fval;
    c_out  = cin;
    hc_out = 1'b0;
    vf_out = 1'b0;
    case (sel)
      `BBX_ALU_OR:   res = wval | fval;
      `BBX_ALU_DEC:  res = fval - 8'h01;
      `BBX_ALU_INC:  res = fval + 8'h01;
      `BBX_ALU_RLC: begin
        res   = {fval[6:0], cin};
        c_out = fval[7];
      end
      `BBX_ALU_SUBB: begin
        // w - f - borrow, borrow is the inverted carry
        sum    = {1'b0, wval} + {1'b0, ~fval} + {8'h00, cin};
        lsum   = {1'b0, wval[3:0]} + {1'b0, ~fval[3:0]} + {4'h0, cin};
        res    = sum[7:0];
        c_out  = sum[8];
        hc_out = lsum[4];
        vf_out = (wval[7] ^ fval[7]) & (sum[7] ^ wval[7]);
      end
      `BBX_ALU_BSET: res = fval | (8'h01 << bsel);
      `BBX_ALU_BCLR: res = fval & ~(8'h01 << bsel);
      `BBX_ALU_PASSW: res = wval;
      `BBX_ALU_CLR:  res = 8'h00;
      `BBX_ALU_SET:  res = 8'hff;
      default:       res = fval;
    endcase
  end

  assign z_out = (res == 8'h00);
  assign n_out = res[7];
endmodule
`default_nettype wire

// ---- design/bbx_core.v ----
// execute core for byte, bit and branch instructions
`timescale 1ns/100ps
`default_nettype none
`include "bbx_defs.vh"
module bbx_core (
  // clock and reset
  input  wire        clk,
  input  wire        nrst,
  // program memory
  output reg  [20:0] prog_addr_r,
  input  wire [15:0] prog_data,
  // data register file
  output reg  [11:0] data_addr_r,
  input  wire [7:0]  data_rd_data,
  output reg         data_wr_r,
  output reg  [7:0]  data_wr_data_r,
  // port pins and timer zero
  input  wire [7:0]  port_pins,
  input  wire        tz_psc_assigned,
  output reg         tz_psc_clr_r,
  // core state
  output reg  [1:0]  phase_r,
  output reg  [7:0]  working_register_r,
  output reg  [4:0]  status_r,
  output reg  [15:0] product_register_pair_r,
  output reg  [3:0]  bank_select_register_r
);
  // instruction kinds
  localparam [3:0] K_NONE = 4'h0;
  localparam [3:0] K_BYTE = 4'h1;
  localparam [3:0] K_MUL  = 4'h2;
  localparam [3:0] K_CMP  = 4'h3;
  localparam [3:0] K_BTST = 4'h4;
  localparam [3:0] K_NEG  = 4'h5;
  localparam [3:0] K_REL  = 4'h6;
  localparam [3:0] K_MF1  = 4'h7;
  localparam [3:0] K_MF2  = 4'h8;

  reg  [15:0] ir_r;
  reg         mff_pend_r;
  reg  [7:0]  hold_r;
  reg         take_r;
  reg         skip_r;
  reg  [20:0] target_r;

  wire [7:0]  pins_s;
  wire [3:0]  op_hi = ir_r[15:12];
  wire        d_bit = ir_r[9];
  wire        a_bit = ir_r[8];
  wire [7:0]  f_lit = ir_r[7:0];
  wire [2:0]  b_sel = ir_r[11:9];

  reg  [3:0]  kind;
  reg  [3:0]  alu_sel;
  reg  [4:0]  fmask;
  reg         use_d;
  reg         force_f;
  reg         skip_z;
  reg         skip_nz;
  reg  [11:0] eff_addr;

  wire [7:0]  rd_val;
  wire [7:0]  alu_res;
  wire        alu_c;
  wire        alu_hc;
  wire        alu_vf;
  wire        alu_z;
  wire        alu_n;
  wire [15:0] alu_prod;
  wire [4:0]  alu_flags;
  wire        to_file;
  wire        cmp_hit;
  wire        bit_hit;
  wire [20:0] off_neg;
  wire [20:0] off_rel;

  bbx_sync #(
    .W (8)
  ) u_pin_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in (port_pins),
    .sync_out (pins_s)
  );

  bbx_alu u_alu (
    .sel    (alu_sel),
    .fval   (rd_val),
    .wval   (working_register_r),
    .cin    (status_r[`BBX_ST_C]),
    .bsel   (b_sel),
    .res    (alu_res),
    .c_out  (alu_c),
    .hc_out (alu_hc),
    .vf_out (alu_vf),
    .z_out  (alu_z),
    .n_out  (alu_n),
    .prod   (alu_prod)
  );

  // port reads see the pins, so read-modify-write copies pin levels
  assign rd_val = (data_addr_r == `BBX_ADDR_PORT) ? pins_s : data_rd_data;

  assign alu_flags = {alu_n, alu_vf, alu_z, alu_hc, alu_c};
  assign to_file   = force_f | (use_d & d_bit);

  // compare and bit-test conditions
  assign cmp_hit = (ir_r[10:9] == 2'b00) ? (rd_val < working_register_r) :
                   (ir_r[10:9] == 2'b01) ? (rd_val == working_register_r) :
                   (rd_val > working_register_r);
  assign bit_hit = (op_hi == `BBX_OP_BTSC) ? ~rd_val[b_sel] : rd_val[b_sel];

  // pc is already one word on, so target is that plus 2n
  assign off_neg = {{12{ir_r[7]}}, ir_r[7:0], 1'b0};
  assign off_rel = {{9{ir_r[10]}}, ir_r[10:0], 1'b0};

  // address selection
  always @* begin
    if (a_bit) begin
      eff_addr = {bank_select_register_r, f_lit};
    end else if (f_lit[7]) begin
      eff_addr = {`BBX_ACC_HI_BANK, f_lit};
    end else begin
      eff_addr = {4'h0, f_lit};
    end
    if (kind == K_MF1 || kind == K_MF2) begin
      eff_addr = ir_r[11:0];
    end
  end

  // instruction decode
  always @* begin
    kind    = K_NONE;
    alu_sel = `BBX_ALU_PASSF;
    fmask   = 5'h00;
    use_d   = 1'b0;
    force_f = 1'b0;
    skip_z  = 1'b0;
    skip_nz = 1'b0;
    case (op_hi)
      `BBX_OP_MUL: begin
        if (ir_r[11:9] == 3'b001) begin
          kind = K_MUL;
        end
      end
      `BBX_OP_IOR: begin
        if (ir_r[11:10] == 2'b00) begin
          kind    = K_BYTE;
          alu_sel = `BBX_ALU_OR;
          fmask   = `BBX_FM_ZN;
          use_d   = 1'b1;
        end
      end
      `BBX_OP_DECSZ: begin
        if (ir_r[11:10] == 2'b11) begin
          kind    = K_BYTE;
          alu_sel = `BBX_ALU_DEC;
          use_d   = 1'b1;
          skip_z  = 1'b1;
        end
      end
      `BBX_OP_INC_RLC: begin
        if (ir_r[11:10] == 2'b11) begin
          kind    = K_BYTE;
          alu_sel = `BBX_ALU_INC;
          use_d   = 1'b1;
          skip_z  = 1'b1;
        end else if (ir_r[11:10] == 2'b01) begin
          kind    = K_BYTE;
          alu_sel = `BBX_ALU_RLC;
          fmask   = `BBX_FM_CZN;
          use_d   = 1'b1;
        end
      end
      `BBX_OP_SNZ: begin
        if (ir_r[11] == 1'b1) begin
          kind    = K_BYTE;
          alu_sel = ir_r[10] ? `BBX_ALU_DEC : `BBX_ALU_INC;
          use_d   = 1'b1;
          skip_nz = 1'b1;
        end
      end
      `BBX_OP_MOV_SUB: begin
        if (ir_r[11:10] == 2'b00) begin
          kind    = K_BYTE;
          fmask   = `BBX_FM_ZN;
          use_d   = 1'b1;
        end else if (ir_r[11:10] == 2'b01) begin
          kind    = K_BYTE;
          alu_sel = `BBX_ALU_SUBB;
          fmask   = `BBX_FM_ALL;
          use_d   = 1'b1;
        end
      end
      `BBX_OP_CMP: begin
        case (ir_r[11:9])
          3'b000, 3'b001, 3'b010: kind = K_CMP;
          3'b100: begin
            kind    = K_BYTE;
            alu_sel = `BBX_ALU_SET;
            force_f = 1'b1;
          end
          3'b101: begin
            kind    = K_BYTE;
            alu_sel = `BBX_ALU_CLR;
            fmask   = `BBX_FM_Z;
            force_f = 1'b1;
          end
          3'b111: begin
            kind    = K_BYTE;
            alu_sel = `BBX_ALU_PASSW;
            force_f = 1'b1;
          end
          default: kind = K_NONE;
        endcase
      end
      `BBX_OP_BSET, `BBX_OP_BCLR: begin
        kind    = K_BYTE;
        alu_sel = ir_r[12] ? `BBX_ALU_BCLR : `BBX_ALU_BSET;
        force_f = 1'b1;
      end
      `BBX_OP_BTSS, `BBX_OP_BTSC: kind = K_BTST;
      `BBX_OP_MFF1: kind = K_MF1;
      `BBX_OP_REL: begin
        if (!ir_r[11]) begin
          kind = K_REL;
        end
      end
      `BBX_OP_BR: begin
        if (ir_r[11:8] == `BBX_SUB_NEG) begin
          kind = K_NEG;
        end
      end
      `BBX_OP_MFF2: begin
        // lone second word stays a no-operation
        if (mff_pend_r) begin
          kind = K_MF2;
        end
      end
      default: kind = K_NONE;
    endcase
  end

  // phase sequencer and execution
  always @(posedge clk) begin
    if (!nrst) begin
      phase_r                 <= `BBX_PH_DECODE;
      prog_addr_r             <= `BBX_PC_RESET;
      ir_r                    <= `BBX_NOP_WORD;
      mff_pend_r              <= 1'b0;
      hold_r                  <= 8'h00;
      take_r                  <= 1'b0;
      skip_r                  <= 1'b0;
      target_r                <= `BBX_PC_RESET;
      data_addr_r             <= 12'h000;
      data_wr_r               <= 1'b0;
      data_wr_data_r          <= 8'h00;
      tz_psc_clr_r            <= 1'b0;
      working_register_r      <= 8'h00;
      status_r                <= `BBX_ST_RESET;
      product_register_pair_r <= 16'h0000;
      bank_select_register_r  <= 4'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
      case (phase_r)
        `BBX_PH_DECODE: begin
          data_addr_r <= eff_addr;
          take_r      <= 1'b0;
          skip_r      <= 1'b0;
        end
        `BBX_PH_READ: begin
          target_r <= prog_addr_r + ((kind == K_REL) ? off_rel : off_neg);
        end
        `BBX_PH_PROCESS: begin
          case (kind)
            K_BYTE: begin
              if (to_file) begin
                data_wr_r      <= 1'b1;
                data_wr_data_r <= alu_res;
                if (data_addr_r == `BBX_ADDR_BANK) begin
                  bank_select_register_r <= alu_res[3:0];
                end
                if (data_addr_r == `BBX_ADDR_TZC && tz_psc_assigned) begin
                  tz_psc_clr_r <= 1'b1;
                end
              end else begin
                working_register_r <= alu_res;
              end
              status_r <= (status_r & ~fmask) | (alu_flags & fmask);
              skip_r   <= (skip_z & alu_z) | (skip_nz & ~alu_z);
            end
            K_MUL: product_register_pair_r <= alu_prod;
            K_CMP: skip_r <= cmp_hit;
            K_BTST: skip_r <= bit_hit;
            K_NEG: take_r <= status_r[`BBX_ST_N];
            K_REL: take_r <= 1'b1;
            K_MF1: hold_r <= rd_val;
            K_MF2: begin
              data_wr_r      <= 1'b1;
              data_wr_data_r <= hold_r;
              if (data_addr_r == `BBX_ADDR_BANK) begin
                bank_select_register_r <= hold_r[3:0];
              end
              if (data_addr_r == `BBX_ADDR_TZC && tz_psc_assigned) begin
                tz_psc_clr_r <= 1'b1;
              end
            end
            default: take_r <= 1'b0;
          endcase
        end
        `BBX_PH_WRITE: begin
          data_wr_r      <= 1'b0;
          tz_psc_clr_r   <= 1'b0;
          mff_pend_r     <= (kind == K_MF1);
          if (take_r) begin
            // flush the prefetch; next cycle is the no-operation
            prog_addr_r <= target_r;
            ir_r        <= `BBX_NOP_WORD;
          end else if (skip_r) begin
            // discarded word runs as a no-operation
            prog_addr_r <= prog_addr_r + `BBX_PC_STEP;
            ir_r        <= `BBX_NOP_WORD;
          end else begin
            prog_addr_r <= prog_addr_r + `BBX_PC_STEP;
            ir_r        <= prog_data;
          end
        end
        default: phase_r <= `BBX_PH_DECODE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- tb/bbx_core_chk.sv ----
// port assertions for the byte/bit execute core
`timescale 1ns/100ps
`default_nettype none
module bbx_core_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // memory side
  input wire logic [20:0] prog_addr_r,
  input wire logic [11:0] data_addr_r,
  input wire logic        data_wr_r,
  // timer zero
  input wire logic        tz_psc_assigned,
  input wire logic        tz_psc_clr_r,
  // core state
  input wire logic [1:0]  phase_r,
  input wire logic [7:0]  working_register_r,
  input wire logic [4:0]  status_r,
  input wire logic [15:0] product_register_pair_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_phase_step; 1'b1 |=> phase_r == $past(phase_r) + 2'h1; endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase did not advance");
  property p_wr_phase; data_wr_r |-> phase_r == 2'h3; endproperty
  a_wr_phase: assert property (p_wr_phase) else $error("write outside write phase");
  property p_wr_pulse; data_wr_r |=> !data_wr_r; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  property p_psc_cause;
    tz_psc_clr_r |-> data_wr_r && data_addr_r == 12'hfd0 && tz_psc_assigned;
  endproperty
  a_psc_cause: assert property (p_psc_cause) else $error("prescaler cleared without cause");
  property p_psc_given;
    data_wr_r && data_addr_r == 12'hfd0 && tz_psc_assigned |-> tz_psc_clr_r;
  endproperty
  a_psc_given: assert property (p_psc_given) else $error("prescaler clear missing");
  property p_pc_moment; $changed(prog_addr_r) |-> phase_r == 2'h0; endproperty
  a_pc_moment: assert property (p_pc_moment) else $error("pc moved mid cycle");
  property p_pc_even; prog_addr_r[0] == 1'b0; endproperty
  a_pc_even: assert property (p_pc_even) else $error("odd program address");
  property p_flag_moment; $changed(status_r) |-> phase_r == 2'h3; endproperty
  a_flag_moment: assert property (p_flag_moment) else $error("flags moved mid cycle");
  property p_mul_keeps_w;
    $changed(product_register_pair_r) |-> $stable(working_register_r);
  endproperty
  a_mul_keeps_w: assert property (p_mul_keeps_w) else $error("multiply changed w");
  property p_addr_moment; $changed(data_addr_r) |-> phase_r == 2'h1; endproperty
  a_addr_moment: assert property (p_addr_moment) else $error("address moved mid cycle");
endmodule

bind bbx_core bbx_core_chk i_chk (
  .clk                     (clk),
  .nrst                    (nrst),
  .prog_addr_r             (prog_addr_r),
  .data_addr_r             (data_addr_r),
  .data_wr_r               (data_wr_r),
  .tz_psc_assigned         (tz_psc_assigned),
  .tz_psc_clr_r            (tz_psc_clr_r),
  .phase_r                 (phase_r),
  .working_register_r      (working_register_r),
  .status_r                (status_r),
  .product_register_pair_r (product_register_pair_r)
);
`default_nettype wire

// ---- tb/bbx_mem_model.sv ----
// program memory and data register file beside the core
`timescale 1ns/100ps
`default_nettype none
module bbx_mem_model (
  // clock
  input  wire logic        clk,
  // program memory
  input  wire logic [20:0] prog_addr,
  output logic      [15:0] prog_data,
  // data register file
  input  wire logic [11:0] data_addr,
  output logic      [7:0]  data_rd_data,
  input  wire logic        data_wr,
  input  wire logic [7:0]  data_wr_data
);
  logic [15:0] prog [0:63];
  logic [7:0]  mem  [0:4095];
  // past the loaded image every word reads as a no-operation
  assign prog_data    = (prog_addr < 21'h000080) ? prog[prog_addr[6:1]] : 16'h0000;
  assign data_rd_data = mem[data_addr];
  always @(posedge clk) begin
    if (data_wr) begin
      mem[data_addr] <= data_wr_data;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_bbx_core.sv ----
// self-checking testbench for the execute core
`timescale 1ns/100ps
`default_nettype none
module tb_bbx_core;
  logic        clk = 1'b0;
  logic        nrst;
  logic [7:0]  port_pins;
  logic        tz_psc_assigned;
  wire  [20:0] prog_addr_r;
  wire  [15:0] prog_data;
  wire  [11:0] data_addr_r;
  wire  [7:0]  data_rd_data;
  wire         data_wr_r;
  wire  [7:0]  data_wr_data_r;
  wire         tz_psc_clr_r;
  wire  [1:0]  phase_r;
  wire  [7:0]  working_register_r;
  wire  [4:0]  status_r;
  wire  [15:0] product_register_pair_r;
  wire  [3:0]  bank_select_register_r;
  int          errors;
  int          tests_run;
  int          psc_cnt;

  always #20 clk = ~clk;

  bbx_core i_dut (
    .clk(clk), .nrst(nrst), .prog_addr_r(prog_addr_r), .prog_data(prog_data),
    .data_addr_r(data_addr_r), .data_rd_data(data_rd_data), .data_wr_r(data_wr_r),
    .data_wr_data_r(data_wr_data_r), .port_pins(port_pins),
    .tz_psc_assigned(tz_psc_assigned), .tz_psc_clr_r(tz_psc_clr_r),
    .phase_r(phase_r), .working_register_r(working_register_r), .status_r(status_r),
    .product_register_pair_r(product_register_pair_r),
    .bank_select_register_r(bank_select_register_r)
  );
  bbx_mem_model i_mem (
    .clk(clk), .prog_addr(prog_addr_r), .prog_data(prog_data), .data_addr(data_addr_r),
    .data_rd_data(data_rd_data), .data_wr(data_wr_r), .data_wr_data(data_wr_data_r)
  );

  always @(negedge clk) begin
    if (tz_psc_clr_r === 1'b1) psc_cnt++;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic start(input logic [15:0] w [$]);
    for (int i = 0; i < 64; i++) i_mem.prog[i] = (i < w.size()) ? w[i] : 16'h0000;
    for (int i = 0; i < 4096; i++) i_mem.mem[i] = 8'h00;
    psc_cnt = 0;
  endtask

  // reset, run, and note the clock at which a write to watch first shows
  task automatic run(input logic [11:0] watch, output int hit);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    hit = 0;
    for (int n = 1; n <= 160; n++) begin
      @(negedge clk);
      if (hit == 0 && data_wr_r === 1'b1 && data_addr_r === watch) hit = n;
    end
  endtask

  task automatic t_byte_ops();
    int hit;
    start('{16'h8610, 16'h9e11, 16'h1012, 16'h0213, 16'h1214, 16'h12e0, 16'h8110,
            16'h8015, 16'hd7ff});
    i_mem.mem[12'h011] = 8'hff;
    i_mem.mem[12'h012] = 8'h85;
    i_mem.mem[12'h013] = 8'h02;
    i_mem.mem[12'hfe0] = 8'h02;
    tz_psc_assigned = 1'b0;
    run(12'h710, hit);
    check("bit set", i_mem.mem[12'h010], 16'h0008);
    check("bit clear", i_mem.mem[12'h011], 16'h007f);
    check("or into w", working_register_r, 16'h0085);
    check("product", product_register_pair_r, 16'h010a);
    check("or into file", i_mem.mem[12'h014], 16'h0085);
    check("bank select", bank_select_register_r, 16'h0007);
    check("banked bit set", i_mem.mem[12'h710], 16'h0001);
    check("access bank kept", i_mem.mem[12'h015], 16'h0001);
    check("flags", status_r, 16'h0010);
    check("single cycle timing", 16'(hit), 16'd31);
    check("no prescaler clear", 16'(psc_cnt), 16'd0);
    $display("test byte ops done");
  endtask

  task automatic t_skips();
    int hit;
    start('{16'h2e20, 16'h8021, 16'h3e22, 16'h8221, 16'h6223, 16'h8421, 16'hb024,
            16'h8621, 16'ha224, 16'h8821, 16'hd001, 16'h8a21, 16'h8c21, 16'h6423,
            16'h8025, 16'h6023, 16'h8225, 16'hd7ff});
    i_mem.mem[12'h020] = 8'h01;
    i_mem.mem[12'h022] = 8'hff;
    i_mem.mem[12'h024] = 8'hfe;
    run(12'h021, hit);
    check("decrement result", i_mem.mem[12'h020], 16'h0000);
    check("increment result", i_mem.mem[12'h022], 16'h0000);
    check("skipped ops", i_mem.mem[12'h021], 16'h0040);
    check("unskipped ops", i_mem.mem[12'h025], 16'h0003);
    check("flags kept", status_r, 16'h0000);
    check("skip and branch timing", 16'(hit), 16'd55);
    $display("test skips done");
  endtask

  task automatic t_flags_moves();
    int hit;
    start('{16'he601, 16'h8030, 16'h5280, 16'h52d0, 16'h3631, 16'h3432, 16'h5433,
            16'he601, 16'h8230, 16'hc034, 16'hf035, 16'hf030, 16'hd7ff});
    i_mem.mem[12'h031] = 8'h81;
    i_mem.mem[12'h032] = 8'h80;
    i_mem.mem[12'h033] = 8'h02;
    i_mem.mem[12'h034] = 8'h5a;
    tz_psc_assigned = 1'b1;
    run(12'h035, hit);
    check("branch not taken", i_mem.mem[12'h030], 16'h0001);
    check("rotate", i_mem.mem[12'h031], 16'h0002);
    check("subtract result", working_register_r, 16'h00ff);
    check("subtract flags", status_r, 16'h0010);
    check("file move", i_mem.mem[12'h035], 16'h005a);
    check("lone second word", i_mem.mem[12'h030], 16'h0001);
    check("pin read back", i_mem.mem[12'hf80], 16'h00a5);
    check("prescaler clears", 16'(psc_cnt), 16'd1);
    check("move timing", 16'(hit), 16'd47);
    tz_psc_assigned = 1'b0;
    $display("test flags and moves done");
  endtask

  task automatic t_extra_ops();
    int hit;
    start('{16'h4e40, 16'h8041, 16'h4a42, 16'h8241, 16'h5046, 16'h6ed0, 16'h6843,
            16'h6a44, 16'hd7ff});
    i_mem.mem[12'h040] = 8'h02;
    i_mem.mem[12'h042] = 8'hff;
    i_mem.mem[12'h044] = 8'h33;
    i_mem.mem[12'h046] = 8'h3c;
    run(12'h044, hit);
    check("decrement not zero", i_mem.mem[12'h040], 16'h0001);
    check("skip then no skip", i_mem.mem[12'h041], 16'h0002);
    check("increment to zero", i_mem.mem[12'h042], 16'h0000);
    check("w to timer zero", i_mem.mem[12'hfd0], 16'h003c);
    check("unassigned prescaler", 16'(psc_cnt), 16'd0);
    check("set file", i_mem.mem[12'h043], 16'h00ff);
    check("clear file", i_mem.mem[12'h044], 16'h0000);
    check("w after move", working_register_r, 16'h003c);
    check("clear flags", status_r, 16'h0004);
    check("extra op timing", 16'(hit), 16'd35);
    $display("test extra ops done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    port_pins = 8'ha5;
    tz_psc_assigned = 1'b0;
    errors = 0;
    tests_run = 0;
    psc_cnt = 0;
    @(negedge clk);
    t_byte_ops();
    t_skips();
    t_flags_moves();
    t_extra_ops();
    give_verdict();
  end

  initial begin
    #(40 * 2000);
    errors++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule
`default_nettype wire
